// File: ird_pkg.sv
// Constants for the interrupt-return decode block.
// Assumes a 14-bit instruction word and an 8-bit interrupt control register.
package ird_pkg;
  // ==========================================================================
  // Instruction encodings
  localparam int INSN_W = 14;
  localparam logic [13:0] RET_IRQ_OPCODE = 14'h0009;
  localparam logic [13:0] STORE_ACC_MASK = 14'h3F80;
  localparam logic [13:0] STORE_ACC_MATCH = 14'h0080;
  localparam logic [13:0] NOP_MASK = 14'h3F9F;
  localparam logic [13:0] NOP_MATCH = 14'h0000;
  localparam int FILE_ADDR_W = 7;
  // ==========================================================================
  // Register layout
  localparam int DATA_W = 8;
  localparam int IRQ_ENABLE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ==========================================================================
  // Phase encoding and cycle counts
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam int RET_IRQ_CYCLES = 2;
  typedef enum logic [1:0] {
    IRD_OP_OTHER,
    IRD_OP_RET_IRQ,
    IRD_OP_STORE_ACC,
    IRD_OP_NOP
  } ird_op_e;
endpackage : ird_pkg

// File: ird_phase_gen.sv
// Four-phase generator that splits each instruction cycle into Q1..Q4.
// Assumes one free-running clock; one clock per phase.
`timescale 1ns/10ps
`default_nettype none
module ird_phase_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Phase outputs
  output logic [1:0] phase,
  output logic cycle_start
);
  logic [1:0] next_phase;

  // ==========================================================================
  // Phase counter
  // Wraps every four clocks; Q1 marks the start of an instruction cycle
  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= ird_pkg::PHASE_Q4;
    end else begin
      phase <= next_phase;
    end
  end

  assign cycle_start = (phase == ird_pkg::PHASE_Q1);
endmodule : ird_phase_gen
`default_nettype wire

// File: ird_core.sv
// Decode and execution control for the return-from-interrupt instruction.
// Assumes the fetch unit presents a stable word for the whole cycle, and
// that the return stack is outside and shows its top entry combinationally.
`timescale 1ns/10ps
`default_nettype none
module ird_core #(
  parameter int PC_W = 13
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Instruction, return stack and accumulator
  input wire logic [13:0] INSN_WORD,
  input wire logic [PC_W-1:0] STACK_TOP_ENTRY,
  input wire logic [7:0] ACCUMULATOR,
  // Program counter, stack control and phase
  output logic [PC_W-1:0] PROGRAM_COUNTER,
  output logic STACK_POP,
  output logic [1:0] PHASE,
  output logic PIPE_FLUSH,
  // Interrupt control register
  output logic [7:0] INTERRUPT_CONTROL_REG,
  output logic GLOBAL_IRQ_ENABLE,
  // Register-store request
  output logic FILE_WRITE,
  output logic [6:0] FILE_ADDR,
  output logic [7:0] FILE_DATA
);
  logic [1:0] phase;
  logic cycle_start;
  ird_pkg::ird_op_e op;
  ird_pkg::ird_op_e next_op;
  logic second_cycle;
  logic next_second_cycle;
  logic [PC_W-1:0] next_pc;
  logic next_pop;
  logic next_flush;
  logic [7:0] next_ctrl;
  logic next_write;
  logic [6:0] next_addr;
  logic [7:0] next_data;
  logic in_q3;
  logic in_q4;
  logic ret_q3;
  logic ret_q4;
  logic store_q4;
  logic idle_q4;

  // ==========================================================================
  // Decode
  function automatic ird_pkg::ird_op_e decode(input logic [13:0] w);
    if (w == ird_pkg::RET_IRQ_OPCODE) begin
      decode = ird_pkg::IRD_OP_RET_IRQ;
    end else if ((w & ird_pkg::STORE_ACC_MASK) == ird_pkg::STORE_ACC_MATCH) begin
      decode = ird_pkg::IRD_OP_STORE_ACC;
    end else if ((w & ird_pkg::NOP_MASK) == ird_pkg::NOP_MATCH) begin
      decode = ird_pkg::IRD_OP_NOP;
    end else begin
      decode = ird_pkg::IRD_OP_OTHER;
    end
  endfunction : decode

  // Next sequential address; wraps silently at the top of program space
  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    pc_inc = pc + {{(PC_W-1){1'b0}}, 1'b1};
  endfunction : pc_inc

  ird_phase_gen u_phase (
    .clk(REF_CLK),
    .reset_n(RESET_N),
    .phase(phase),
    .cycle_start(cycle_start)
  );

  // ==========================================================================
  // Phase qualifiers
  // A return acts only in its first cycle; the idle cycle behind it
  // carries a forced no-op, so a stale word there can never act
  assign in_q3 = (phase == ird_pkg::PHASE_Q3);
  assign in_q4 = (phase == ird_pkg::PHASE_Q4);
  assign ret_q3 = (op == ird_pkg::IRD_OP_RET_IRQ) && !second_cycle && in_q3;
  assign ret_q4 = (op == ird_pkg::IRD_OP_RET_IRQ) && !second_cycle && in_q4;
  assign store_q4 = (op == ird_pkg::IRD_OP_STORE_ACC) && in_q4;
  assign idle_q4 = (op == ird_pkg::IRD_OP_NOP) && second_cycle && in_q4;

  // ==========================================================================
  // Instruction sequencing
  // The word fetched behind a return is stale, so its cycle is forced idle.
  // The flag stays up through that whole cycle and drops at its Q4, so the
  // program counter logic can tell a forced idle from a real no-op
  always_comb begin
    next_op = op;
    next_second_cycle = second_cycle;
    if (cycle_start) begin
      if (second_cycle) begin
        next_op = ird_pkg::IRD_OP_NOP;
      end else begin
        next_op = decode(INSN_WORD);
      end
    end
    if (ret_q4) begin
      next_second_cycle = 1'b1;
    end else if (idle_q4) begin
      next_second_cycle = 1'b0;
    end
  end

  // Reset looks like the last clock of an idle cycle, so the first Q4
  // after release does not move the program counter off zero
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      op <= ird_pkg::IRD_OP_NOP;
      second_cycle <= 1'b1;
    end else begin
      op <= next_op;
      second_cycle <= next_second_cycle;
    end
  end

  // ==========================================================================
  // Program counter
  // Advances once at the end of every executed cycle. A return loads the
  // popped entry instead, and the forced idle cycle leaves it as loaded
  always_comb begin
    next_pc = PROGRAM_COUNTER;
    if (ret_q4) begin
      next_pc = STACK_TOP_ENTRY;
    end else if (in_q4 && !second_cycle) begin
      next_pc = pc_inc(PROGRAM_COUNTER);
    end
  end

  // Program counter register
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PROGRAM_COUNTER <= '0;
    end else begin
      PROGRAM_COUNTER <= next_pc;
    end
  end

  // ==========================================================================
  // Stack pop and pipeline flush
  // Both pulse for one clock as the return's first cycle ends. The stack
  // sits outside, so the pop is only a strobe; the flush tells fetch to
  // drop the word it took from the old address
  always_comb begin
    next_pop = ret_q4;
    next_flush = ret_q4;
  end

  // Pulse registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      STACK_POP <= 1'b0;
      PIPE_FLUSH <= 1'b0;
    end else begin
      STACK_POP <= next_pop;
      PIPE_FLUSH <= next_flush;
    end
  end

  // ==========================================================================
  // Interrupt control register
  // Only the enable bit is ever written, and only upward: whatever clears
  // it lives outside this block. Setting it in Q3 means the enable is
  // already up before the pop strobe rises at the end of Q4
  always_comb begin
    next_ctrl = INTERRUPT_CONTROL_REG;
    if (ret_q3) begin
      next_ctrl[ird_pkg::IRQ_ENABLE_BIT] = 1'b1;
    end
  end

  // The level output is a registered copy of the same bit
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INTERRUPT_CONTROL_REG <= ird_pkg::CTRL_RESET;
      GLOBAL_IRQ_ENABLE <= 1'b0;
    end else begin
      INTERRUPT_CONTROL_REG <= next_ctrl;
      GLOBAL_IRQ_ENABLE <= next_ctrl[ird_pkg::IRQ_ENABLE_BIT];
    end
  end

  // ==========================================================================
  // Register-store request
  // Address and data are taken in Q4 while the word is still the store's
  // own; they hold afterwards, and only the write strobe pulses
  always_comb begin
    next_write = store_q4;
    next_addr = FILE_ADDR;
    next_data = FILE_DATA;
    if (store_q4) begin
      next_addr = INSN_WORD[ird_pkg::FILE_ADDR_W-1:0];
      next_data = ACCUMULATOR;
    end
  end

  // Store request registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FILE_WRITE <= 1'b0;
      FILE_ADDR <= '0;
      FILE_DATA <= '0;
    end else begin
      FILE_WRITE <= next_write;
      FILE_ADDR <= next_addr;
      FILE_DATA <= next_data;
    end
  end

  // ==========================================================================
  // Phase output
  // A registered copy, so the pin trails the internal phase by one clock
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PHASE <= ird_pkg::PHASE_Q1;
    end else begin
      PHASE <= phase;
    end
  end
endmodule : ird_core
`default_nettype wire

// File: ird_properties.sv
// ====
// Checker for the interrupt-return decode block.
// Sees only the top module ports and is bound to ird_core below.
`timescale 1ns/10ps
`default_nettype none
module ird_properties #(
  parameter int PC_W = 13
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Watched ports
  input wire logic [PC_W-1:0] STACK_TOP_ENTRY,
  input wire logic [PC_W-1:0] PROGRAM_COUNTER,
  input wire logic STACK_POP,
  input wire logic PIPE_FLUSH,
  input wire logic [7:0] INTERRUPT_CONTROL_REG,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic FILE_WRITE
);
  // One domain, so clock and reset are given once
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_pop_flush_pair: assert property (STACK_POP == PIPE_FLUSH)
    else $error("flush differs from pop");
  a_pop_one_clock: assert property (STACK_POP |=> !STACK_POP)
    else $error("pop longer than one clock");
  a_pc_loads_top: assert property (
    STACK_POP |-> PROGRAM_COUNTER == $past(STACK_TOP_ENTRY))
    else $error("pc not loaded from stack top");
  a_enable_before_pop: assert property (STACK_POP |-> $past(GLOBAL_IRQ_ENABLE))
    else $error("enable not set before pop");
  a_enable_bit_seven: assert property (GLOBAL_IRQ_ENABLE == INTERRUPT_CONTROL_REG[7])
    else $error("enable differs from bit 7");
  a_ctrl_low_clear: assert property (INTERRUPT_CONTROL_REG[6:0] == 7'h00)
    else $error("other control bits changed");
  // Second cycle is idle: no pop, no store, pc held until the next decode
  a_idle_after_pop: assert property (STACK_POP |=>
    (!STACK_POP && !FILE_WRITE && $stable(PROGRAM_COUNTER))[*7])
    else $error("second cycle not idle");
endmodule : ird_properties
bind ird_core ird_properties #(.PC_W(PC_W)) u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .STACK_TOP_ENTRY(STACK_TOP_ENTRY), .PROGRAM_COUNTER(PROGRAM_COUNTER),
  .STACK_POP(STACK_POP), .PIPE_FLUSH(PIPE_FLUSH), .FILE_WRITE(FILE_WRITE),
  .INTERRUPT_CONTROL_REG(INTERRUPT_CONTROL_REG), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
`default_nettype wire

// File: testbench.sv
// ====
// Self-checking bench for ird_core with an instruction-level model.
// Assumes one word per 4-clock cycle and 8 clocks for a return.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] insn_word = 14'h0000;
  logic [12:0] top_entry = 13'h0000;
  logic [7:0] acc = 8'h00;
  logic [12:0] pc, m_pc = 13'h0000;
  logic pop, flush, global_irq_enable, fw, e_pop = 1'b0, e_fw = 1'b0;
  logic [7:0] ctrl, fdata, e_ctrl = 8'h00, e_data;
  logic [6:0] faddr, e_addr;
  logic [1:0] ph;
  int fails = 0;
  int compares = 0;
  ird_core #(.PC_W(13)) DUT (.REF_CLK(ref_clk), .RESET_N(reset_n), .INSN_WORD(insn_word),
    .STACK_TOP_ENTRY(top_entry), .ACCUMULATOR(acc), .PROGRAM_COUNTER(pc), .STACK_POP(pop),
    .PHASE(ph), .PIPE_FLUSH(flush), .INTERRUPT_CONTROL_REG(ctrl), .GLOBAL_IRQ_ENABLE(global_irq_enable),
    .FILE_WRITE(fw), .FILE_ADDR(faddr), .FILE_DATA(fdata));
  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // Compare against the model after the last edge of a cycle
  task automatic check_end;
    chk(pc, m_pc);
    chk(pop, e_pop);
    chk(flush, e_pop);
    chk(fw, e_fw);
    chk(ctrl, e_ctrl);
    chk(ph, ird_pkg::PHASE_Q4);
    if (e_fw) chk({faddr, fdata}, {e_addr, e_data});
  endtask : check_end
  // One instruction: 0 return, 1 store, 2 no-op with random spare bits
  task automatic step(input int kind);
    logic [13:0] w;
    w = kind == 0 ? 14'h0009 : kind == 1 ? {7'h01, 7'($urandom)} : {7'h00, 2'($urandom), 5'h00};
    insn_word <= w;
    top_entry <= 13'($urandom);
    acc <= 8'($urandom);
    #1;
    check_end();
    e_addr = w[6:0];
    e_data = acc;
    e_fw = kind == 1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(ph, ird_pkg::PHASE_Q3);
    if (kind == 0) begin
      e_ctrl = 8'h80;
      chk(global_irq_enable, 1'b1);
      chk(pop, 1'b0);
    end
    @(posedge ref_clk);
    m_pc = kind == 0 ? top_entry : m_pc + 13'h0001;
    if (kind == 0) begin
      // A store in the idle cycle must be ignored
      insn_word <= 14'h00FF;
      #1;
      e_pop = 1'b1;
      check_end();
      e_pop = 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask : step
  // Main sequence: a no-op and a store, then back-to-back returns, then random
  initial begin
    void'($urandom(36));
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // The core decodes on the second edge after release, so words change on Q1 edges
    @(posedge ref_clk);
    step(2);
    step(1);
    step(0);
    step(0);
    for (int i = 0; i < 20; i++) step(int'($urandom_range(2)));
    #1;
    check_end();
    wrap_up();
  end
  // Watchdog well beyond 24 instructions of 8 clocks
  initial begin
    repeat (1000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
